// ### hw/adcrm_pkg.sv
// package for the adc register map and status block
// assumes a single 10 MHz clock domain; no other dependencies
package adcrm_pkg;
  // register select codes
  localparam logic [3:0] SEL_STATUS = 4'h0;
  localparam logic [3:0] SEL_CFG = 4'h1;
  localparam logic [3:0] SEL_GPIO = 4'h2;
  localparam logic [3:0] SEL_GAINCAL = 4'h3;
  localparam logic [3:0] SEL_RESULT = 4'h4;
  localparam logic [3:0] SEL_SYS_OFS = 4'h5;
  localparam logic [3:0] SEL_SYS_GAIN = 4'h6;
  localparam logic [3:0] SEL_SC_OFS = 4'h7;
  localparam logic [3:0] SEL_SC_GAIN = 4'h8;
  localparam logic [3:0] SEL_LAST = 4'h8;
  // reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h02;
  localparam logic [7:0] RST_GPIO = 8'h0F;
  localparam logic [7:0] RST_GAINCAL = 8'h1E;
  localparam logic [23:0] RST_WIDE = 24'h000000;
  // status field positions
  localparam int ST_CAL_OR = 7;
  localparam int ST_RATE_HI = 6;
  localparam int ST_RATE_LO = 4;
  localparam int ST_OVER = 3;
  localparam int ST_UNDER = 2;
  localparam int ST_BUSY = 1;
  localparam int ST_READY = 0;
  // command byte field positions
  localparam int CMD_MODE = 6;
  localparam int CMD_SEL_HI = 4;
  localparam int CMD_SEL_LO = 1;
  localparam int CMD_WRITE = 0;
  // gpio control fields
  localparam int GPIO_DIR_LO = 4;
  localparam int GPIO_N = 4;
  // saturation of the self-calibration gain coefficient, 1.9999999 in 1.23 format
  localparam logic [23:0] SC_GAIN_MAX = 24'hFFFFFF;
endpackage

// ### hw/adcrm_regs.sv
// register map and status flags of a serial delta-sigma converter
// assumes the serial framer delivers decoded command bytes and data words
// synchronously, and the conversion engine reports events as one-cycle pulses
// the gpio pads sit outside; an output enable bit high means the pad is driven
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - select codes 0 to 8 pick nine registers
// - widths 8/24; reset values 02,0F,1E, else zero
// - status read-only, writes ignored, reads flags
// - calibration overrange sets status bit 7
// - bits 6..4 hold rate of last result or calibration
// - bit 3 flags clipped high, clears otherwise
// - bit 2 flags clipped low, clears otherwise
// - bit 1 follows modulator busy
// - bit 0 sets on new result
// - read while not busy clears ready only after next start
// - read during conversion clears ready after read
// - primary configuration readable and writable
// - mode bit one means register access
// - gpio direction picks pin input or driven value
module adcrm_regs (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic enable_i, // freezes all state when low
  // command byte from the serial framer
  input wire logic cmd_valid_i, // one-cycle strobe with cmd_byte_i
  input wire logic [7:0] cmd_byte_i,
  // write data for a register access, after the command
  input wire logic wr_valid_i, // one-cycle strobe
  input wire logic [23:0] wr_data_i,
  // end of a read transfer (last bit shifted out)
  input wire logic rd_done_i,
  // conversion engine events
  input wire logic conv_start_i, // pulse: conversion or calibration started
  input wire logic [2:0] conv_rate_i, // rate code of the started operation
  input wire logic busy_i, // modulator busy level
  input wire logic result_valid_i, // pulse: new result with result_i
  input wire logic [23:0] result_i,
  input wire logic result_over_i, // result was clipped at maximum
  input wire logic result_under_i, // result was clipped at minimum
  input wire logic cal_done_i, // pulse: calibration finished
  input wire logic cal_overrange_i, // with cal_done_i: system gain overranged
  input wire logic coeff_valid_i, // pulse: engine writes a coefficient
  input wire logic [3:0] coeff_sel_i,
  input wire logic [23:0] coeff_i,
  // gpio pins
  input wire logic [3:0] gpio_in_i,
  output logic [3:0] gpio_out_o,
  output logic [3:0] gpio_oe_o,
  // register read answer
  output logic rd_valid_o, // pulse, one cycle
  output logic [23:0] rd_data_o,
  output logic rd_wide_o, // answer is 24 bits, else 8
  // control fields to the rest of the converter
  output logic [7:0] config_o,
  output logic [7:0] gain_cal_o,
  output logic [7:0] status_o
);
  import adcrm_pkg::*;
  // timing of a register access, counted from the edge that takes the command:
  // a write lands at the edge that takes wr_valid_i and shows one cycle later;
  // a read answer is registered one edge after the command, because the wide
  // words sit behind a registered memory read; the answer then holds until
  // the host ends the transfer with rd_done_i
  // commands that arrive while an access is open are ignored, not queued,
  // which keeps the sequencer to three states at the cost of host discipline

  // access sequencer: gray coded along idle -> wait data -> read
  typedef enum logic [1:0] {
    ADCRM_IDLE = 2'b00,
    ADCRM_WDATA = 2'b01,
    ADCRM_RDATA = 2'b11
  } adcrm_state_t;

  typedef struct packed {
    adcrm_state_t state;
    logic [3:0] sel; // latched register select
    // host-writable control registers
    logic [7:0] config_reg;
    logic [7:0] gpio_reg;
    logic [7:0] gaincal_reg;
    // status flags, read-only to the host
    logic cal_or; // status bit 7
    logic [2:0] rate; // status bits 6..4
    logic over; // status bit 3
    logic under; // status bit 2
    logic busy; // status bit 1
    logic ready; // status bit 0
    // ready-flag bookkeeping and read answer
    logic read_seen; // result read since it was stored
    logic rd_pend; // read answer waits one cycle for memory
    logic rd_valid;
    logic [23:0] rd_data;
    logic rd_wide;
    // registered pin drive
    logic [3:0] gpio_out;
    logic [3:0] gpio_oe;
  } adcrm_regs_t;

  adcrm_regs_t s_reg;
  adcrm_regs_t s_next;

  // wide memory port signals
  logic mem_we;
  logic [2:0] mem_waddr;
  logic [23:0] mem_wdata;
  logic [2:0] mem_raddr;
  logic [23:0] mem_rdata;

  // map a select code to a memory index; only valid for codes 4..8
  // codes C..F alias onto indexes 0..3 and codes 9..B give 5..7, so callers must gate with is_wide
  function automatic logic [2:0] wide_index(input logic [3:0] sel);
    logic [3:0] d;
    d = sel - SEL_RESULT;
    return d[2:0];
  endfunction

  // true for the five 24-bit registers
  function automatic logic is_wide(input logic [3:0] sel);
    return (sel >= SEL_RESULT) && (sel <= SEL_LAST);
  endfunction

  // gpio read view: inputs show the pin, outputs the stored bit
  // the direction nibble reads back as written
  function automatic logic [7:0] gpio_view(input logic [7:0] r, input logic [3:0] pins);
    logic [3:0] dir;
    dir = r[GPIO_DIR_LO +: GPIO_N];
    return {dir, (dir & r[3:0]) | (~dir & pins)};
  endfunction

  // result and coefficients share one registered memory; the engine write
  // wins a collision and the host coefficient write is then dropped
  adcrm_wide_mem #(
    .WIDTH(24),
    .DEPTH(5)
  ) u_mem (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .enable_i(enable_i),
    .wr_en_i(mem_we),
    .wr_addr_i(mem_waddr),
    .wr_data_i(mem_wdata),
    .rd_addr_i(mem_raddr),
    .rd_data_o(mem_rdata)
  );

  // next-state logic for the whole block
  always_comb begin
    logic [23:0] sat;
    sat = '0;
    s_next = s_reg;
    s_next.rd_valid = 1'b0;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;

    // engine events other than the ready flag are handled first; a host read below still answers with the registered flags
    // modulator busy follows the engine level
    s_next.busy = busy_i;

    // engine writes: result and calibration coefficients
    if (result_valid_i) begin
      mem_we = 1'b1;
      mem_waddr = wide_index(SEL_RESULT);
      mem_wdata = result_i;
      s_next.over = result_over_i;
      s_next.under = result_under_i;
    end else if (coeff_valid_i && is_wide(coeff_sel_i) && (coeff_sel_i != SEL_RESULT)) begin
      mem_we = 1'b1;
      mem_waddr = wide_index(coeff_sel_i);
      // self-cal gain cannot exceed its maximum code
      sat = coeff_i;
      if ((coeff_sel_i == SEL_SC_GAIN) && (coeff_i > SC_GAIN_MAX)) begin
        sat = SC_GAIN_MAX;
      end
      mem_wdata = sat;
    end

    // rate of the result or calibration now in place
    if (result_valid_i || cal_done_i) begin
      s_next.rate = conv_rate_i;
    end
    if (cal_done_i) begin
      s_next.cal_or = cal_overrange_i;
    end

    // command decode and register accesses
    case (s_reg.state)
      // idle: only a register-access byte opens a transfer
      ADCRM_IDLE: begin
        if (cmd_valid_i && cmd_byte_i[CMD_MODE]) begin
          s_next.sel = cmd_byte_i[CMD_SEL_HI:CMD_SEL_LO];
          if (!cmd_byte_i[CMD_WRITE]) begin
            s_next.state = ADCRM_WDATA;
          end else begin
            s_next.state = ADCRM_RDATA;
            s_next.rd_pend = 1'b1;
          end
        end
      end
      // waiting for the data word of a write
      ADCRM_WDATA: begin
        if (wr_valid_i) begin
          s_next.state = ADCRM_IDLE;
          case (s_reg.sel)
            SEL_STATUS: ;
            SEL_CFG: s_next.config_reg = wr_data_i[7:0];
            SEL_GPIO: s_next.gpio_reg = wr_data_i[7:0];
            SEL_GAINCAL: s_next.gaincal_reg = wr_data_i[7:0];
            SEL_RESULT: ; // result is read-only
            default: begin
              // coefficients; codes 9..F fall through unwritten
              // a host write loses to an engine write in the same cycle
              if (is_wide(s_reg.sel) && !result_valid_i && !coeff_valid_i) begin
                mem_we = 1'b1;
                mem_waddr = wide_index(s_reg.sel);
                mem_wdata = wr_data_i;
              end
            end
          endcase
        end
      end
      // read: answer once, then wait for the host to finish
      ADCRM_RDATA: begin
        // one cycle after the command the memory word is ready
        if (s_reg.rd_pend) begin
          s_next.rd_pend = 1'b0;
          s_next.rd_valid = 1'b1;
          s_next.rd_wide = is_wide(s_reg.sel);
          case (s_reg.sel)
            SEL_STATUS: s_next.rd_data = {16'h0000, status_o};
            SEL_CFG: s_next.rd_data = {16'h0000, s_reg.config_reg};
            SEL_GPIO: s_next.rd_data = {16'h0000, gpio_view(s_reg.gpio_reg, gpio_in_i)};
            SEL_GAINCAL: s_next.rd_data = {16'h0000, s_reg.gaincal_reg};
            default: s_next.rd_data = is_wide(s_reg.sel) ? mem_rdata : 24'h000000;
          endcase
        end else if (rd_done_i) begin
          s_next.state = ADCRM_IDLE;
          if (s_reg.sel == SEL_RESULT) begin
            s_next.read_seen = 1'b1;
            // read during the following conversion clears at once
            if (s_reg.busy) begin
              s_next.ready = 1'b0;
            end
          end
        end
      end
      default: s_next.state = ADCRM_IDLE;
    endcase

    // the memory address follows the select being latched, so a read issued
    // now finds its word in the memory output register one edge later
    mem_raddr = wide_index(s_next.sel);

    // a read that ended while busy has already cleared ready above
    // a start clears ready only if the result was read
    if (conv_start_i && s_next.read_seen) begin
      s_next.ready = 1'b0;
    end
    // new result sets ready; set wins over any clear
    if (result_valid_i) begin
      s_next.ready = 1'b1;
      s_next.read_seen = 1'b0;
    end

    // gpio pins driven from registers
    s_next.gpio_oe = s_next.gpio_reg[GPIO_DIR_LO +: GPIO_N];
    s_next.gpio_out = s_next.gpio_reg[3:0];
  end

  // single state register, constant reset
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      // flags, sequencer and read answer clear;
      // control registers take their power-on values
      s_reg <= '0;
      s_reg.state <= ADCRM_IDLE;
      s_reg.config_reg <= RST_CFG;
      s_reg.gpio_reg <= RST_GPIO;
      s_reg.gaincal_reg <= RST_GAINCAL;
      s_reg.rd_data <= RST_WIDE;
    end else if (enable_i) begin
      // a low enable holds every field, the memory port included
      s_reg <= s_next;
    end
  end

  // outputs straight from flip-flops
  // the status byte is a plain concatenation of flops, so a status read
  // returns status_o as it stood in the cycle before the answer
  always_comb begin
    gpio_out_o = s_reg.gpio_out;
    gpio_oe_o = s_reg.gpio_oe;
    rd_valid_o = s_reg.rd_valid;
    rd_data_o = s_reg.rd_data;
    rd_wide_o = s_reg.rd_wide;
    config_o = s_reg.config_reg;
    gain_cal_o = s_reg.gaincal_reg;
    status_o = {s_reg.cal_or, s_reg.rate, s_reg.over, s_reg.under, s_reg.busy, s_reg.ready};
  end
endmodule
`default_nettype wire

// ### hw/adcrm_wide_mem.sv
// five-word memory for the 24-bit registers (result and coefficients)
// assumes single clock; read data registered, one write port
`timescale 1ns/100ps
`default_nettype none
module adcrm_wide_mem #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 5
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic wr_en_i,
  input wire logic [2:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [2:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem [DEPTH]; // word storage
  // write and registered read; reset clears all words
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rd_data_o <= '0;
    end else if (enable_i) begin
      if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
        mem[wr_addr_i] <= wr_data_i;
      end
      // out-of-range reads give zero
      rd_data_o <= (int'(rd_addr_i) < DEPTH) ? mem[rd_addr_i] : '0;
    end
  end
endmodule
`default_nettype wire

// ### verif/adcrm_host_model.sv
// host side model: issues register access commands
// assumes the block answers reads within a few cycles
`timescale 1ns/100ps
`default_nettype none
module adcrm_host_model (
  input wire logic clock_i,
  input wire logic rd_valid_i,
  input wire logic [23:0] rd_data_i,
  output logic cmd_valid_o,
  output logic [7:0] cmd_byte_o,
  output logic wr_valid_o,
  output logic [23:0] wr_data_o,
  output logic rd_done_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_byte_o = 8'h00;
    wr_valid_o = 1'b0;
    wr_data_o = 24'h000000;
    rd_done_o = 1'b0;
  end
  // released lines invert so stale data never passes for valid
  task automatic send_cmd(input logic [3:0] sel, input logic rd);
    @(posedge clock_i);
    cmd_valid_o <= 1'b1;
    cmd_byte_o <= {3'b110, sel, rd};
    @(posedge clock_i);
    cmd_valid_o <= 1'b0;
    cmd_byte_o <= ~{3'b110, sel, rd};
  endtask
  // data follows the command at the next edge
  task automatic reg_wr(input logic [3:0] sel, input logic [23:0] d);
    send_cmd(sel, 1'b0);
    wr_valid_o <= 1'b1;
    wr_data_o <= d;
    @(posedge clock_i);
    wr_valid_o <= 1'b0;
    wr_data_o <= ~d;
  endtask
  // bounded wait for the answer, then end the transfer
  task automatic reg_rd(input logic [3:0] sel, output logic [23:0] d, output logic ok);
    int n;
    send_cmd(sel, 1'b1);
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (rd_valid_i !== 1'b1 && n < 8);
    ok = (rd_valid_i === 1'b1);
    d = rd_data_i;
    @(posedge clock_i);
    rd_done_o <= 1'b1;
    @(posedge clock_i);
    rd_done_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verif/adcrm_regs_monitor.sv
// checker for the register map and status block
// assumes enable_i held high; bound to the block's ports
`timescale 1ns/100ps
`default_nettype none
module adcrm_regs_monitor (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic [2:0] conv_rate_i,
  input wire logic busy_i,
  input wire logic result_valid_i,
  input wire logic result_over_i,
  input wire logic result_under_i,
  input wire logic cal_done_i,
  input wire logic cal_overrange_i,
  input wire logic rd_valid_o,
  input wire logic [7:0] status_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // an answer only ever follows a read command two edges back
  chk_read_latency: assert property (
    rd_valid_o |-> $past(cmd_valid_i, 2) && $past(cmd_byte_i[6], 2) && $past(cmd_byte_i[0], 2))
    else $error("read answer without read command");
  chk_read_pulse: assert property (rd_valid_o |=> !rd_valid_o)
    else $error("read answer longer than one cycle");
  // busy flag trails the modulator by one cycle
  chk_busy_follow: assert property (status_o[1] == $past(busy_i))
    else $error("busy flag does not follow modulator");
  chk_ready_set: assert property (result_valid_i |=> status_o[0])
    else $error("ready not set by new result");
  chk_over_flag: assert property (result_valid_i |=> status_o[3] == $past(result_over_i))
    else $error("over flag wrong");
  chk_under_flag: assert property (result_valid_i |=> status_o[2] == $past(result_under_i))
    else $error("under flag wrong");
  chk_rate_code: assert property (
    result_valid_i || cal_done_i |=> status_o[6:4] == $past(conv_rate_i))
    else $error("rate code wrong");
  chk_cal_over: assert property (cal_done_i |=> status_o[7] == $past(cal_overrange_i))
    else $error("calibration overrange flag wrong");
endmodule
bind adcrm_regs adcrm_regs_monitor u_adcrm_regs_monitor (.clock_i(clock_i), .reset_i(reset_i),
  .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i), .conv_rate_i(conv_rate_i),
  .busy_i(busy_i), .result_valid_i(result_valid_i), .result_over_i(result_over_i),
  .result_under_i(result_under_i), .cal_done_i(cal_done_i),
  .cal_overrange_i(cal_overrange_i), .rd_valid_o(rd_valid_o), .status_o(status_o));
`default_nettype wire

// ### verif/test_adcrm_regs.sv
// testbench for the register map block
// assumes host model and checker files compiled first
`timescale 1ns/100ps
`default_nettype none
module test_adcrm_regs;
  import adcrm_pkg::*;
  logic clock_i, reset_i, cmd_valid_i, wr_valid_i, rd_done_i, conv_start_i, busy_i;
  logic result_valid_i, result_over_i, result_under_i, cal_done_i, cal_overrange_i;
  logic rd_valid_o, rd_wide_o, ok, coeff_valid_i;
  logic [2:0] conv_rate_i;
  logic [3:0] gpio_in_i, gpio_out_o, gpio_oe_o, coeff_sel_i;
  logic [7:0] cmd_byte_i, config_o, gain_cal_o, status_o, w;
  logic [23:0] wr_data_i, result_i, rd_data_o, got, d, coeff_i;
  logic [23:0] shadow [16]; // expected register contents
  int err_total, tests_run;
  // enable held high; the engine coefficient port is driven by eng_coeff
  adcrm_regs u_adcrm_regs (.clock_i(clock_i), .reset_i(reset_i), .enable_i(1'b1),
    .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i), .wr_valid_i(wr_valid_i),
    .wr_data_i(wr_data_i), .rd_done_i(rd_done_i), .conv_start_i(conv_start_i),
    .conv_rate_i(conv_rate_i), .busy_i(busy_i), .result_valid_i(result_valid_i),
    .result_i(result_i), .result_over_i(result_over_i), .result_under_i(result_under_i),
    .cal_done_i(cal_done_i), .cal_overrange_i(cal_overrange_i), .coeff_valid_i(coeff_valid_i),
    .coeff_sel_i(coeff_sel_i), .coeff_i(coeff_i), .gpio_in_i(gpio_in_i),
    .gpio_out_o(gpio_out_o), .gpio_oe_o(gpio_oe_o), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .rd_wide_o(rd_wide_o), .config_o(config_o),
    .gain_cal_o(gain_cal_o), .status_o(status_o));
  adcrm_host_model u_adcrm_host_model (.clock_i(clock_i), .rd_valid_i(rd_valid_o),
    .rd_data_i(rd_data_o), .cmd_valid_o(cmd_valid_i), .cmd_byte_o(cmd_byte_i),
    .wr_valid_o(wr_valid_i), .wr_data_o(wr_data_i), .rd_done_o(rd_done_i));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] seen);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a missing answer ends the run
  task automatic rd(input logic [3:0] s, input logic [23:0] exp);
    u_adcrm_host_model.reg_rd(s, got, ok);
    if (!ok) begin
      err_total++;
      $display("ERROR read answer of register %h expected 1 seen 0", s);
      end_of_test();
    end else begin
      chk($sformatf("register %h", s), exp, got);
      chk("wide flag", 24'(s inside {[4:8]}), 24'(rd_wide_o));
    end
  endtask
  task automatic rd_all;
    for (int s = 0; s < 16; s++) rd(s[3:0], shadow[s]);
  endtask
  // level flags checked once settled
  task automatic stat(input int b, input logic e);
    repeat (2) @(negedge clock_i);
    chk($sformatf("status bit %0d", b), 24'(e), 24'(status_o[b]));
  endtask
  task automatic start(input logic [2:0] r);
    @(posedge clock_i);
    conv_start_i <= 1'b1;
    conv_rate_i <= r;
    busy_i <= 1'b1;
    @(posedge clock_i);
    conv_start_i <= 1'b0;
  endtask
  task automatic finish(input logic [23:0] v, input logic o, input logic u);
    @(posedge clock_i);
    busy_i <= 1'b0;
    result_valid_i <= 1'b1;
    result_i <= v;
    result_over_i <= o;
    result_under_i <= u;
    @(posedge clock_i);
    result_valid_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    shadow[4] = v;
  endtask
  task automatic cal(input logic [2:0] r, input logic ov);
    @(posedge clock_i);
    cal_done_i <= 1'b1;
    cal_overrange_i <= ov;
    conv_rate_i <= r;
    @(posedge clock_i);
    cal_done_i <= 1'b0;
  endtask
  // engine writes a coefficient through its own port
  task automatic eng_coeff(input logic [3:0] s, input logic [23:0] v);
    @(posedge clock_i);
    coeff_valid_i <= 1'b1;
    coeff_sel_i <= s;
    coeff_i <= v;
    @(posedge clock_i);
    coeff_valid_i <= 1'b0;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial begin
    {reset_i, conv_start_i, busy_i, result_valid_i, cal_done_i} = 5'b10000;
    {result_over_i, result_under_i, cal_overrange_i, conv_rate_i} = 6'h00;
    result_i = 24'h000000;
    {coeff_valid_i, coeff_sel_i} = 5'h00;
    coeff_i = 24'h000000;
    gpio_in_i = 4'hF;
    err_total = 0;
    tests_run = 0;
    foreach (shadow[i]) shadow[i] = 24'h000000;
    shadow[1] = 24'h000002;
    shadow[2] = 24'h00000F;
    shadow[3] = 24'h00001E;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    rd_all();
    $display("test reset values done");
    gpio_in_i <= 4'h0;
    for (int s = 0; s < 16; s++) begin
      d = 24'h5A5A5A ^ {6{s[3:0]}};
      u_adcrm_host_model.reg_wr(s[3:0], d);
      if (s inside {[1:3]}) shadow[s] = {16'h0000, d[7:0]};
      if (s inside {[5:8]}) shadow[s] = d;
    end
    w = shadow[2][7:0];
    shadow[2][3:0] = w[3:0] & w[7:4];
    rd_all();
    chk("config", shadow[1], 24'(config_o));
    chk("gain cal", shadow[3], 24'(gain_cal_o));
    chk("gpio oe", 24'(w[7:4]), 24'(gpio_oe_o));
    chk("gpio out", 24'(w[3:0] & w[7:4]), 24'(gpio_out_o & gpio_oe_o));
    $display("test write all done");
    for (int i = 0; i < 3; i++) begin
      start(3'(i + 5));
      finish(24'h800000 + 24'(i), i == 1, i == 2);
      shadow[0] = {16'h0000, 1'b0, 3'(i + 5), i == 1, i == 2, 2'b01};
      rd(SEL_STATUS, shadow[0]);
      rd(SEL_RESULT, shadow[4]);
    end
    $display("test conversions done");
    start(3'h1);
    stat(ST_READY, 1'b0);
    finish(24'h00ABCD, 1'b0, 1'b0);
    start(3'h2);
    stat(ST_READY, 1'b1);
    rd(SEL_RESULT, 24'h00ABCD);
    stat(ST_READY, 1'b0);
    finish(24'h00BEEF, 1'b0, 1'b0);
    rd(SEL_RESULT, 24'h00BEEF);
    stat(ST_READY, 1'b1);
    $display("test ready flag done");
    cal(3'h6, 1'b1);
    rd(SEL_STATUS, 24'h0000E1);
    cal(3'h3, 1'b0);
    rd(SEL_STATUS, 24'h000031);
    $display("test calibration done");
    eng_coeff(SEL_SC_GAIN, SC_GAIN_MAX);
    rd(SEL_SC_GAIN, SC_GAIN_MAX);
    eng_coeff(SEL_SYS_GAIN, 24'h13579B);
    rd(SEL_SYS_GAIN, 24'h13579B);
    $display("test coefficients done");
    end_of_test();
  end
endmodule
`default_nettype wire
